// ---- logic/atc_translation_completion.sv ----
// Forms translation completions for endpoint device TLBs and updates
// first-level accessed, extended-accessed and dirty flags in memory.
// Assumes an AHB-Lite master for registers and a memory port that
// honours mem_lock_o as a bus lock across a read and its write.
//
// Summary of operation
// - No translation or no permission: zeroed success.
// - User request on supervisor entry: zeroed success.
// - Second-level address beyond width limit: zeroed success.
// - Second-level entry with R=W=0 stops walk.
// - Walk read/write ANDs both clear: zeroed success.
// - Good walk returns success with computed bits.
// - Read bit follows applicable access check.
// - No-write request clears write if supported.
// - Write bit follows applicable access check.
// - Execute needs PASID, request and support.
// - Privilege set when supervisor entry controls.
// - Global copies leaf first-level bit with PASID.
// - No-snoop: PASID one, else gated snoop attribute.
// - Untranslated-only copies transient mapping unless first-level.
// - Size bit marks pages above 4 KB.
// - Address carries walk output when usable.
// - PASID requests translate normally in interrupt window.
// - Set accessed flag in every used entry.
// - Set extended-accessed when enable bit is one.
// - Set dirty in leaf entry per no-write.
// - Flags updated before completion is returned.
// - Flags set only when access checks pass.
`timescale 1ns/1ps
`default_nettype none
module atc_translation_completion (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Paging-entry memory port.
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic             mem_lock_o,
	output logic [31:0]      mem_addr_o,
	output logic [63:0]      mem_wdata_o,
	input  wire logic [63:0] mem_rdata_i,
	input  wire logic        mem_ack_i,
	// Completion toward the endpoint.
	output logic             cpl_valid_o,
	output logic [63:0]      cpl_data_o
);
	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	// Register index of a bus address; bit 4 flags a mapped word.
	function automatic logic [4:0] reg_dec(input logic [31:0] a);
		reg_dec = (a[31:6] == 26'h0) ? {1'b1, a[5:2]} : 5'h00;
	endfunction
	// Mask of the levels a walk of depth d+1 touches.
	function automatic logic [3:0] lvl_mask(input logic [1:0] d);
		lvl_mask = 4'hf >> (2'h3 - d);
	endfunction
	// ------------------------------------------------------------
	// Register storage.
	// ------------------------------------------------------------
	logic [31:0]       req_ff;           // Request attributes.
	logic [31:0]       cap_ff;           // Capabilities.
	logic [63:0]       in_addr_ff;       // Input address.
	logic [63:0]       out_addr_ff;      // Walk output address.
	logic [31:0]       ent_ff [atc_pkg::NUM_ENT]; // First-level entry pointers.
	atc_pkg::atc_state_t state_ff;       // Flag-update sequencer.
	logic [63:0]       res_ff;           // Latched completion data.
	logic              zero_ff;          // Latched zeroed result.
	logic              flags_ff;         // Flag walk required.
	logic              eae_ff;           // Extended accessed wanted.
	logic              dirty_ff;         // Dirty wanted on leaf.
	logic [1:0]        depth_ff;         // Last first-level index.
	logic [1:0]        idx_ff;           // Entry being updated.
	logic              dphase_ff;        // Write data phase pending.
	logic [4:0]        wreg_ff;          // Decoded write target.
	logic              start;            // Start strobe this cycle.

	// The slave never stalls and never errors.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ------------------------------------------------------------
	// Bus address phase.
	// ------------------------------------------------------------
	// Read data is fetched at the address phase so it stands in the data
	// phase; a read right after a write to the same word sees the old value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dphase_ff <= 1'b0;
			wreg_ff   <= 5'h00;
			hrdata    <= 32'h0;
		end else begin
			dphase_ff <= hsel & hready & htrans[1] & hwrite;
			wreg_ff   <= reg_dec(haddr);
			if (hsel & hready & htrans[1] & !hwrite) begin
				hrdata <= rd_mux(reg_dec(haddr));
			end
		end
	end

	// Read multiplexer; unmapped words read as zero.
	function automatic logic [31:0] rd_mux(input logic [4:0] r);
		rd_mux = 32'h0;
		if (r[4]) begin
			case (r[3:0])
				atc_pkg::REG_REQ:    rd_mux = req_ff;
				atc_pkg::REG_CAP:    rd_mux = cap_ff;
				atc_pkg::REG_IN_LO:  rd_mux = in_addr_ff[31:0];
				atc_pkg::REG_IN_HI:  rd_mux = in_addr_ff[63:32];
				atc_pkg::REG_OUT_LO: rd_mux = out_addr_ff[31:0];
				atc_pkg::REG_OUT_HI: rd_mux = out_addr_ff[63:32];
				4'h6, 4'h7, 4'h8, 4'h9: rd_mux = ent_ff[r[1:0] + 2'h2];
				atc_pkg::REG_STAT:   rd_mux = {30'h0, zero_ff, state_ff != atc_pkg::ST_IDLE};
				atc_pkg::REG_CPL_LO: rd_mux = cpl_data_o[31:0];
				atc_pkg::REG_CPL_HI: rd_mux = cpl_data_o[63:32];
				default:             rd_mux = 32'h0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// Bus data phase: configuration writes.
	// ------------------------------------------------------------
	// Configuration is frozen while a request is in flight so the latched
	// result and the flag walk stay consistent.
	wire idle = (state_ff == atc_pkg::ST_IDLE);
	wire cfg_we = dphase_ff & wreg_ff[4] & idle;
	assign start = cfg_we & (wreg_ff[3:0] == atc_pkg::REG_CTRL) & hwdata[0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_ff      <= 32'h0;
			cap_ff      <= atc_pkg::CAP_RST;
			in_addr_ff  <= 64'h0;
			out_addr_ff <= 64'h0;
		end else if (cfg_we) begin
			case (wreg_ff[3:0])
				atc_pkg::REG_REQ:    req_ff <= hwdata;
				atc_pkg::REG_CAP:    cap_ff <= hwdata;
				atc_pkg::REG_IN_LO:  in_addr_ff[31:0] <= hwdata;
				atc_pkg::REG_IN_HI:  in_addr_ff[63:32] <= hwdata;
				atc_pkg::REG_OUT_LO: out_addr_ff[31:0] <= hwdata;
				atc_pkg::REG_OUT_HI: out_addr_ff[63:32] <= hwdata;
				default:             ;
			endcase
		end
	end

	// Entry pointers, one per first-level walk level.
	genvar gi;
	generate
		for (gi = 0; gi < atc_pkg::NUM_ENT; gi++) begin : g_ent
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ent_ff[gi] <= 32'h0;
				end else if (cfg_we && wreg_ff[3:0] == atc_pkg::REG_ENT0 + 4'(gi)) begin
					ent_ff[gi] <= hwdata;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Completion evaluation.
	// ------------------------------------------------------------
	logic        pasid, nested, sl_used, nw_eff, addr_bad, sl_stop, us_fault;
	logic        rd_ok, wr_ok, zero, u_bit;
	logic [3:0]  slm;
	logic [6:0]  lim;
	logic [63:0] res;

	// Pure function of the configuration registers; latched on start.
	always_comb begin
		pasid   = req_ff[atc_pkg::Q_PASID];
		nested  = req_ff[atc_pkg::Q_NEST];
		sl_used = !pasid | nested;
		slm     = lvl_mask(req_ff[atc_pkg::Q_SLD +: 2]);
		// The interrupt window gets no special case here, PASID or not.
		lim = (cap_ff[atc_pkg::C_MAX_GUEST_ADDR_WIDTH +: 7] < cap_ff[atc_pkg::C_ADJUSTED_GUEST_WIDTH +: 7]) ?
			cap_ff[atc_pkg::C_MAX_GUEST_ADDR_WIDTH +: 7] : cap_ff[atc_pkg::C_ADJUSTED_GUEST_WIDTH +: 7];
		addr_bad = sl_used & (lim < 7'd64) & ((in_addr_ff >> lim) != 64'h0);
		sl_stop  = sl_used & |(slm & ~req_ff[atc_pkg::Q_SLR +: 4]
			& ~req_ff[atc_pkg::Q_SLW +: 4]);
		us_fault = pasid & !req_ff[atc_pkg::Q_PR] & !req_ff[atc_pkg::Q_USALL];
		// Second-level checks alone without a PASID; first-level, plus the
		// second-level ANDs under nesting, with one.
		rd_ok = (!pasid | req_ff[atc_pkg::Q_FLR])
			& (!sl_used | &(req_ff[atc_pkg::Q_SLR +: 4] | ~slm));
		wr_ok = (!pasid | req_ff[atc_pkg::Q_FLW])
			& (!sl_used | &(req_ff[atc_pkg::Q_SLW +: 4] | ~slm));
		zero = !req_ff[atc_pkg::Q_FOUND] | addr_bad | sl_stop | us_fault
			| !(rd_ok | wr_ok);
		nw_eff = req_ff[atc_pkg::Q_NW] & cap_ff[atc_pkg::C_NO_WRITE_FLAG_SUPPORTED];
		u_bit  = !(pasid & !nested) & req_ff[atc_pkg::Q_TM];
		res = 64'h0;
		if (!zero) begin
			res[atc_pkg::P_R] = rd_ok;
			res[atc_pkg::P_W] = wr_ok & !nw_eff;
			res[atc_pkg::P_U] = u_bit;
			res[atc_pkg::P_X] = pasid & req_ff[atc_pkg::Q_ER]
				& cap_ff[atc_pkg::C_ERS] & req_ff[atc_pkg::Q_FLX];
			res[atc_pkg::P_SUPERVISOR_LEVEL_OUT] = pasid & req_ff[atc_pkg::Q_PR]
				& cap_ff[atc_pkg::C_SRS] & !req_ff[atc_pkg::Q_USALL];
			res[atc_pkg::P_G] = pasid & req_ff[atc_pkg::Q_GLOB];
			res[atc_pkg::P_N] = pasid | (cap_ff[atc_pkg::C_SC]
				& req_ff[atc_pkg::Q_SNP]);
			res[atc_pkg::P_S] = req_ff[atc_pkg::Q_LARGE];
			// The size encoding rides in the low address bits of a large page.
			if (!u_bit) begin
				res[63:12] = out_addr_ff[63:12];
			end
		end
	end

	// ------------------------------------------------------------
	// Flag-update sequencer.
	// ------------------------------------------------------------
	logic [63:0] setm;   // Flags to OR into the current entry.
	logic        last;   // Current entry is the leaf.
	always_comb begin
		last  = (idx_ff == depth_ff);
		setm  = 64'h0;
		setm[atc_pkg::F_ACC]    = 1'b1;
		setm[atc_pkg::F_EXTACC] = eae_ff;
		setm[atc_pkg::F_DIRTY]  = last & dirty_ff;
	end

	// Each entry is read and written back under one lock, and the write is
	// skipped when every flag is already set to spare memory traffic.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff    <= atc_pkg::ST_IDLE;
			idx_ff      <= 2'h0;
			mem_addr_o  <= 32'h0;
			mem_wdata_o <= 64'h0;
		end else begin
			case (state_ff)
				atc_pkg::ST_IDLE: begin
					idx_ff     <= 2'h0;
					mem_addr_o <= ent_ff[0];
					if (start) begin
						// Only a passing PASID request touches flags.
						state_ff <= (pasid & !zero) ? atc_pkg::ST_RD : atc_pkg::ST_FIN;
					end
				end
				atc_pkg::ST_RD: begin
					if (mem_ack_i) begin
						mem_wdata_o <= mem_rdata_i | setm;
						if ((mem_rdata_i | setm) != mem_rdata_i) begin
							state_ff <= atc_pkg::ST_WR;
						end else if (last) begin
							state_ff <= atc_pkg::ST_FIN;
						end else begin
							idx_ff     <= idx_ff + 2'h1;
							mem_addr_o <= ent_ff[idx_ff + 2'h1];
						end
					end
				end
				atc_pkg::ST_WR: begin
					if (mem_ack_i) begin
						if (last) begin
							state_ff <= atc_pkg::ST_FIN;
						end else begin
							state_ff   <= atc_pkg::ST_RD;
							idx_ff     <= idx_ff + 2'h1;
							mem_addr_o <= ent_ff[idx_ff + 2'h1];
						end
					end
				end
				// Completion leaves only after every flag write.
				atc_pkg::ST_FIN: state_ff <= atc_pkg::ST_IDLE;
				default:         state_ff <= atc_pkg::ST_IDLE;
			endcase
		end
	end

	// Lock spans the read and its write-back of the same entry.
	assign mem_req_o  = (state_ff == atc_pkg::ST_RD) | (state_ff == atc_pkg::ST_WR);
	assign mem_we_o   = (state_ff == atc_pkg::ST_WR);
	assign mem_lock_o = mem_req_o;

	// ------------------------------------------------------------
	// Result latch and completion output.
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_ff   <= 64'h0;
			zero_ff  <= 1'b0;
			flags_ff <= 1'b0;
			eae_ff   <= 1'b0;
			dirty_ff <= 1'b0;
			depth_ff <= 2'h0;
		end else if (start) begin
			res_ff   <= res;
			zero_ff  <= zero;
			flags_ff <= pasid & !zero;
			eae_ff   <= req_ff[atc_pkg::Q_EAE];
			dirty_ff <= !nw_eff;
			depth_ff <= req_ff[atc_pkg::Q_FLD +: 2];
		end
	end

	// Completion data stand until the next request completes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpl_valid_o <= 1'b0;
			cpl_data_o  <= 64'h0;
		end else begin
			cpl_valid_o <= (state_ff == atc_pkg::ST_FIN);
			if (state_ff == atc_pkg::ST_FIN) begin
				cpl_data_o <= res_ff;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	sequence rd_done_s;
		mem_req_o && !mem_we_o && mem_ack_i;
	endsequence
	sequence fin_s;
		state_ff == atc_pkg::ST_FIN;
	endsequence
	zero_result_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fin_s and zero_ff |=> cpl_valid_o && cpl_data_o[atc_pkg::P_S:0] == 12'h0)
		else $error("zeroed result carries set bits");
	user_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start && pasid && !req_ff[atc_pkg::Q_PR] && !req_ff[atc_pkg::Q_USALL]
		|=> zero_ff && res_ff == 64'h0)
		else $error("user request on supervisor entry not zeroed");
	addr_limit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start && addr_bad |=> zero_ff ##1 !mem_req_o)
		else $error("out of range address not zeroed");
	walk_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start && sl_stop |=> zero_ff && !res_ff[atc_pkg::P_R] && !res_ff[atc_pkg::P_W])
		else $error("absent second-level entry not zeroed");
	no_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start && req_ff[atc_pkg::Q_NW] && cap_ff[atc_pkg::C_NO_WRITE_FLAG_SUPPORTED] |=> !res_ff[atc_pkg::P_W])
		else $error("write granted to no-write request");
	exec_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start && !(pasid && req_ff[atc_pkg::Q_ER] && cap_ff[atc_pkg::C_ERS])
		|=> !res_ff[atc_pkg::P_X])
		else $error("execute granted without support");
	snoop_pasid_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start && pasid && !zero |=> res_ff[atc_pkg::P_N])
		else $error("no-snoop clear on PASID request");
	flag_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		mem_req_o |-> flags_ff && !zero_ff)
		else $error("flag update on failing request");
	lock_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_done_s ##1 mem_we_o |-> mem_lock_o && mem_addr_o == $past(mem_addr_o))
		else $error("write-back not locked to same entry");
	cpl_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cpl_valid_o |-> !mem_req_o && $past(state_ff) == atc_pkg::ST_FIN)
		else $error("completion overlaps flag update");
endmodule
`default_nettype wire

// ---- logic/atc_pkg.sv ----
// Constants shared by the translation completion block.
// Assumes a 32-bit AHB-Lite register bus and a 64-bit paging-entry memory port.
package atc_pkg;
	// ------------------------------------------------------------
	// Register word indexes; the byte address is four times the index.
	// ------------------------------------------------------------
	localparam logic [3:0] REG_REQ    = 4'h0; // Request attributes.
	localparam logic [3:0] REG_CAP    = 4'h1; // Unit capabilities.
	localparam logic [3:0] REG_IN_LO  = 4'h2; // Input address low.
	localparam logic [3:0] REG_IN_HI  = 4'h3; // Input address high.
	localparam logic [3:0] REG_OUT_LO = 4'h4; // Walk output address low.
	localparam logic [3:0] REG_OUT_HI = 4'h5; // Walk output address high.
	localparam logic [3:0] REG_ENT0   = 4'h6; // First of four entry pointers.
	localparam logic [3:0] REG_CTRL   = 4'ha; // Write bit 0 to start.
	localparam logic [3:0] REG_STAT   = 4'hb; // Busy and result state.
	localparam logic [3:0] REG_CPL_LO = 4'hc; // Completion data low.
	localparam logic [3:0] REG_CPL_HI = 4'hd; // Completion data high.
	localparam int         NUM_ENT    = 4;    // Walk depth limit.
	// ------------------------------------------------------------
	// Request register fields.
	// ------------------------------------------------------------
	localparam int Q_PASID = 0;  // Request carries a PASID.
	localparam int Q_NW    = 1;  // no_write_request.
	localparam int Q_ER    = 2;  // execute_requested.
	localparam int Q_PR    = 3;  // supervisor_requested.
	localparam int Q_NEST  = 4;  // Nested translation in force.
	localparam int Q_FOUND = 5;  // Walk found a translation.
	localparam int Q_USALL = 6;  // AND of first-level user_supervisor_flag bits.
	localparam int Q_GLOB  = 7;  // Leaf first-level global bit.
	localparam int Q_SNP   = 8;  // snoop_attribute of leaf second-level entry.
	localparam int Q_TM    = 9;  // transient_mapping of leaf second-level entry.
	localparam int Q_FLR   = 10; // First-level/nested check allows read.
	localparam int Q_FLW   = 11; // First-level/nested check allows write.
	localparam int Q_FLX   = 12; // First-level/nested check allows fetch.
	localparam int Q_LARGE = 13; // Page larger than 4 KB.
	localparam int Q_EAE   = 14; // extended_accessed_enable of PASID entry.
	localparam int Q_SLR   = 16; // Four second-level read bits.
	localparam int Q_SLW   = 20; // Four second-level write bits.
	localparam int Q_SLD   = 24; // Second-level depth minus one, two bits.
	localparam int Q_FLD   = 26; // First-level depth minus one, two bits.
	// ------------------------------------------------------------
	// Capability register fields and reset value.
	// ------------------------------------------------------------
	localparam int          C_NO_WRITE_FLAG_SUPPORTED  = 0;  // no_write_flag_supported.
	localparam int          C_ERS   = 1;  // execute_request_supported.
	localparam int          C_SRS   = 2;  // supervisor_request_support.
	localparam int          C_SC    = 3;  // snoop_control_support.
	localparam int          C_MAX_GUEST_ADDR_WIDTH  = 8;  // max_guest_addr_width, seven bits.
	localparam int          C_ADJUSTED_GUEST_WIDTH  = 16; // adjusted_guest_width, seven bits.
	localparam logic [31:0] CAP_RST = 32'h0030_300f;
	// ------------------------------------------------------------
	// Completion data bits and paging-entry flag bits.
	// ------------------------------------------------------------
	localparam int P_R = 0, P_W = 1, P_U = 2, P_X = 3, P_SUPERVISOR_LEVEL_OUT = 4;
	localparam int P_G = 5, P_N = 6, P_S = 11;
	localparam int F_ACC = 5, F_DIRTY = 6, F_EXTACC = 10;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RD   = 2'h1,
		ST_WR   = 2'h2,
		ST_FIN  = 2'h3
	} atc_state_t;
endpackage

// ---- verification/atc_memory_peer.sv ----
// Memory model holding four 64-bit paging entries for the walk port.
// Assumes entry pointers pick an entry by address bits 4:3.
`timescale 1ns/1ps
`default_nettype none
module atc_memory_peer (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Memory port from the block.
	input  wire logic        mem_req_o,
	input  wire logic        mem_we_o,
	input  wire logic [31:0] mem_addr_o,
	input  wire logic [63:0] mem_wdata_o,
	output logic [63:0]      mem_rdata_i,
	output logic             mem_ack_i
);
	logic [63:0] mem [4]; // Entry storage, preset by the bench.
	int          wait_ff; // Idle cycles left before the next acknowledge.
	// ------------------------------------------------------------
	// Answer each access after 0 to 3 idle cycles.
	// ------------------------------------------------------------
	// Read data toggles outside the acknowledge cycle, so a block that
	// samples it late sees garbage rather than a lucky held value.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_ack_i   <= 1'b0;
			mem_rdata_i <= 64'h5a5a_0000_a5a5_ffff;
			wait_ff     <= 0;
		end else if (mem_ack_i || !mem_req_o) begin
			mem_ack_i   <= 1'b0;
			mem_rdata_i <= ~mem_rdata_i;
		end else if (wait_ff != 0) begin
			wait_ff     <= wait_ff - 1;
			mem_rdata_i <= ~mem_rdata_i;
		end else begin
			mem_ack_i   <= 1'b1;
			mem_rdata_i <= mem[mem_addr_o[4:3]];
			wait_ff     <= $urandom_range(3, 0);
			if (mem_we_o) begin
				mem[mem_addr_o[4:3]] <= mem_wdata_o;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/atc_translation_completion_test.sv ----
// Self-checking bench for the translation completion block.
// Assumes the memory peer model and a single AHB-Lite master here.
`timescale 1ns/1ps
`default_nettype none
module atc_translation_completion_test;
	typedef struct {
		logic [63:0] cpl;     // Expected completion data.
		logic [63:0] mask;    // Completion bits that are defined.
		logic [63:0] mem [4]; // Entries expected when the completion shows.
	} atc_note_t;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, mem_addr_o, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        mem_req_o, mem_we_o, mem_lock_o, mem_ack_i, cpl_valid_o;
	logic [63:0] mem_wdata_o, mem_rdata_i, cpl_data_o;
	logic [63:0] mem0 [4];   // Entry contents before each walk.
	atc_note_t   notes [$];  // Pending expectations, oldest first.
	int          n_errors, num_checks, cyc;
	// Request, capability and input address of each scenario.
	localparam logic [31:0] TQ [11] = '{32'h0133_0120, 32'h0133_0322, 32'h0121_0120,
		32'h0133_0100, 32'h0133_0120, 32'h0133_0120, 32'h0133_0120, 32'h0c00_5ced,
		32'h0400_2c2f, 32'h0400_0c21, 32'h0001_0e71};
	localparam logic [31:0] TC [11] = '{atc_pkg::CAP_RST, 32'h0030_3006, atc_pkg::CAP_RST,
		atc_pkg::CAP_RST, atc_pkg::CAP_RST, atc_pkg::CAP_RST, 32'h0030_280f,
		atc_pkg::CAP_RST, 32'h0030_300d, atc_pkg::CAP_RST, atc_pkg::CAP_RST};
	localparam logic [63:0] TI [11] = '{64'h0, 64'h0, 64'h0, 64'h0, 64'hffff_ffff_f000,
		64'h1_0000_0000_0000, 64'h100_0000_0000, 64'h0, 64'h0, 64'h0, 64'hfee0_1000};
	assign hready = hreadyout;
	atc_translation_completion DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_lock_o(mem_lock_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
		.mem_ack_i(mem_ack_i), .cpl_valid_o(cpl_valid_o), .cpl_data_o(cpl_data_o));
	atc_memory_peer PEER (.hclk(hclk), .hresetn(hresetn), .mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	task automatic cmp64(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One single AHB-Lite word transfer; read data taken at the data phase end.
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// Works out the completion and the entry flags from request and capability.
	function automatic atc_note_t predict(logic [31:0] q, logic [31:0] c,
		logic [63:0] ia, logic [63:0] oa);
		atc_note_t n;
		logic      p, nest, sr, sw, r, w, zero, nwe;
		int        lim;
		p = q[atc_pkg::Q_PASID];
		nest = q[atc_pkg::Q_NEST];
		sr = 1'b1;
		sw = 1'b1;
		for (int i = 0; i <= int'(q[atc_pkg::Q_SLD+:2]); i++) begin
			sr &= q[atc_pkg::Q_SLR+i];
			sw &= q[atc_pkg::Q_SLW+i];
		end
		r = p ? q[atc_pkg::Q_FLR] & (!nest | sr) : sr;
		w = p ? q[atc_pkg::Q_FLW] & (!nest | sw) : sw;
		lim = int'(c[atc_pkg::C_MAX_GUEST_ADDR_WIDTH+:7]);
		if (int'(c[atc_pkg::C_ADJUSTED_GUEST_WIDTH+:7]) < lim) lim = int'(c[atc_pkg::C_ADJUSTED_GUEST_WIDTH+:7]);
		zero = !q[atc_pkg::Q_FOUND] | !(r | w) | (p & !q[atc_pkg::Q_PR] & !q[atc_pkg::Q_USALL])
			| ((!p | nest) & ((ia >> lim) != 0));
		nwe = q[atc_pkg::Q_NW] & c[atc_pkg::C_NO_WRITE_FLAG_SUPPORTED];
		n.cpl = 64'h0;
		n.mask = '1;
		n.mem = mem0;
		if (!zero) begin
			n.cpl[atc_pkg::P_R] = r;
			n.cpl[atc_pkg::P_W] = w & !nwe;
			n.cpl[atc_pkg::P_U] = !(p & !nest) & q[atc_pkg::Q_TM];
			n.cpl[atc_pkg::P_X] = p & q[atc_pkg::Q_ER] & c[atc_pkg::C_ERS] & q[atc_pkg::Q_FLX];
			n.cpl[atc_pkg::P_SUPERVISOR_LEVEL_OUT] = p & q[atc_pkg::Q_PR] & c[atc_pkg::C_SRS] & !q[atc_pkg::Q_USALL];
			n.cpl[atc_pkg::P_G] = p & q[atc_pkg::Q_GLOB];
			n.cpl[atc_pkg::P_N] = p | (c[atc_pkg::C_SC] & q[atc_pkg::Q_SNP]);
			n.cpl[atc_pkg::P_S] = q[atc_pkg::Q_LARGE];
			if (!n.cpl[atc_pkg::P_U]) n.cpl[63:12] = oa[63:12];
			else n.mask[63:12] = '0;
			for (int i = 0; p && i <= int'(q[atc_pkg::Q_FLD+:2]); i++) begin
				n.mem[i][atc_pkg::F_ACC] = 1'b1;
				n.mem[i][atc_pkg::F_EXTACC] |= q[atc_pkg::Q_EAE];
				n.mem[i][atc_pkg::F_DIRTY] |= (i == int'(q[atc_pkg::Q_FLD+:2])) & !nwe;
			end
		end
		return n;
	endfunction
	// Loads one request, starts it and waits for its completion to be seen.
	task automatic run(input logic [31:0] q, input logic [31:0] c, input logic [63:0] ia);
		logic [63:0] oa;
		int          k;
		atc_note_t   e;
		oa = {16'h0, 16'($urandom), $urandom};
		if (q[atc_pkg::Q_LARGE]) oa[20:12] = 9'h0ff;
		if (ia == 64'h0) ia = {36'h0, 28'($urandom)};
		for (int i = 0; i < atc_pkg::NUM_ENT; i++) begin
			mem0[i] = {$urandom, $urandom};
			PEER.mem[i] = mem0[i];
			bus(1'b1, 32'(atc_pkg::REG_ENT0 + i) << 2, 32'h100 + 32'(8 * i));
		end
		bus(1'b1, 32'(atc_pkg::REG_REQ) << 2, q);
		bus(1'b1, 32'(atc_pkg::REG_CAP) << 2, c);
		bus(1'b1, 32'(atc_pkg::REG_IN_LO) << 2, ia[31:0]);
		bus(1'b1, 32'(atc_pkg::REG_IN_HI) << 2, ia[63:32]);
		bus(1'b1, 32'(atc_pkg::REG_OUT_LO) << 2, oa[31:0]);
		bus(1'b1, 32'(atc_pkg::REG_OUT_HI) << 2, oa[63:32]);
		e = predict(q, c, ia, oa);
		notes.push_back(e);
		bus(1'b1, 32'(atc_pkg::REG_CTRL) << 2, 32'h1);
		for (k = 0; notes.size() != 0 && k < 300; k++) @(posedge hclk);
		cmp64(64'(notes.size()), 64'h0);
		// The completion must also read back over the bus until the next one.
		bus(1'b0, 32'(atc_pkg::REG_CPL_LO) << 2, 32'h0);
		cmp64(64'(rd) & e.mask, 64'(e.cpl[31:0]));
		bus(1'b0, 32'(atc_pkg::REG_CPL_HI) << 2, 32'h0);
		cmp64(64'(rd) & 64'(e.mask[63:32]), 64'(e.cpl[63:32]));
		$display("test done: request %h", q);
	endtask
	// Completion watcher: compares data and entry state at the pulse.
	always @(posedge hclk) begin
		atc_note_t n;
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			stop_test;
		end
		if (mem_req_o === 1'b1) cmp64(64'(mem_lock_o), 64'h1);
		if (hresetn === 1'b1) cmp64(64'({hreadyout, hresp}), 64'h2);
		if (cpl_valid_o === 1'b1 && notes.size() == 0) cmp64(64'h1, 64'h0);
		else if (cpl_valid_o === 1'b1) begin
			n = notes.pop_front();
			cmp64(cpl_data_o & n.mask, n.cpl);
			for (int i = 0; i < 4; i++) cmp64(PEER.mem[i], n.mem[i]);
		end
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, hresetn, n_errors, num_checks, cyc} = '0;
		hsize = 3'h2;
		void'($urandom(94));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 32'(atc_pkg::REG_CAP) << 2, 32'h0);
		cmp64(64'(rd), 64'(atc_pkg::CAP_RST));
		bus(1'b0, 32'h38, 32'h0);
		cmp64(64'(rd), 64'h0);
		// Cases: plain, no-write and snoop gating, AND fault, no translation,
		// width limits, supervisor flags, privilege fault, nested window.
		for (int t = 0; t < 11; t++) run(TQ[t], TC[t], TI[t]);
		stop_test;
	end
endmodule
`default_nettype wire
